// ---- design/reset_source_controller.sv ----
// Reset source controller: merges power, pin, software, watchdog and
// alert reset sources into one clock-aligned system reset.
// Assumes i_rst_n is the power-on master reset, analog comparator and
// pin inputs are asynchronous, sleep and boot inputs are on i_sys_clk.
//
// Behaviour
// - Alert monitors may raise a processor interrupt before reset thresholds.
// - Any system reset clears processor, peripherals and their registers.
// - Status register records causes and alerts; only power-on clears it.
// - Power-on trip gives reset of at least 150 ns, stretched while ramping.
// - After boot the power-on monitor stops; precise monitor takes over.
// - Precise monitor trip resets exactly like power-on reset.
// - Software cannot disable digital precise part; regulator off kills analog.
// - Precise monitor off in sleep and hibernate, except periodic sleep samples.
// - Low-voltage alerts take trip settings 1.70 V to 5.45 V, 250 mV steps.
// - High-voltage alert compares against a fixed 5.75 V level.
// - Each low-voltage alert can reset the device instead of interrupting.
// - Alert monitors off until the first boot after power-on completes; sampled in sleep.
// - Alert during sleep sample wakes first, then interrupt is serviced.
// - External pin low holds reset; response equals power-on reset.
// - External reset pin works in sleep and hibernate.
// - Software reset bit, by processor or DMA, resets like power-on.
// - A separate control bit blocks software reset requests.
// - Watchdog resets the device unless restarted within selected timeout.
// - Power-on reset disables the watchdog until firmware enables it.
// - Watchdog enable ignores clears; only power-on reset clears it.
`default_nettype none

module reset_source_controller
  import rst_ctrl_pkg::*;
#(
  parameter int WDT_W = 24,
  parameter logic [WDT_W-1:0] WDT_TIMEOUT_RST = 24'h00FFFF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_supply_ramping,
  input wire logic i_boot_done,
  input wire logic i_sleep,
  input wire logic i_hibernate,
  input wire logic i_precise_dig_trip,
  input wire logic i_precise_ana_trip,
  input wire logic i_dlv_trip,
  input wire logic i_alv_trip,
  input wire logic i_ahv_trip,
  input wire logic i_ext_reset_n,
  output logic o_sys_rst_n,
  output logic o_por_mon_en,
  output logic o_precise_dig_en,
  output logic o_precise_ana_en,
  output logic o_reg_sample_en,
  output logic o_dlv_mon_en,
  output logic o_alv_mon_en,
  output logic o_ahv_mon_en,
  output logic [TRIP_W-1:0] o_dlv_trip_code,
  output logic [TRIP_W-1:0] o_alv_trip_code,
  output logic o_wake_req,
  output logic o_alert_irq
);

  localparam logic [WDT_W-1:0] WDT_ONE = WDT_W'(1);

  typedef struct packed {
    phase_t phase;
    logic [7:0] hold_cnt;
    logic boot_done;
    logic first_done;
    logic [NSRC-1:0] s1;
    logic [NSRC-1:0] s2;
    logic [NSRC-1:0] s3;
    logic [NSRC-1:0] f;
    logic sw_block;
    logic wdt_en;
    logic ana_reg_en;
    logic [ALERT_W-1:0] alert_cfg;
    logic [STATUS_W-1:0] status;
    logic [WDT_W-1:0] wdt_timeout;
    logic [WDT_W-1:0] wdt_cnt;
    logic [15:0] sample_period;
    logic [15:0] sample_cnt;
    logic sample_on;
    logic [3:0] on_cnt;
    logic [2:0] pend;
    logic irq;
    logic wake;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic sys_rst_n;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NSRC-1:0] src;
  logic awake;
  logic alert_act;
  logic pre_trip;
  logic dlv_hit;
  logic alv_hit;
  logic ahv_hit;
  logic alert_rst;
  logic wr_ctrl;
  logic sw_fire;
  logic wdt_fire;
  logic ext_low;
  logic rst_evt;
  logic [2:0] irq_hits;

  assign src = {i_ext_reset_n, i_ahv_trip, i_alv_trip, i_dlv_trip,
                i_precise_ana_trip, i_precise_dig_trip};

  // Monitor enables
  assign awake = !i_sleep && !i_hibernate;
  assign o_por_mon_en = !st_r.boot_done;
  assign o_precise_dig_en = st_r.boot_done &&
    (awake || (i_sleep && !i_hibernate && st_r.sample_on));
  assign o_precise_ana_en = o_precise_dig_en && st_r.ana_reg_en;
  assign o_reg_sample_en = i_sleep && !i_hibernate && st_r.sample_on;
  assign alert_act = st_r.first_done && !i_hibernate &&
    (!i_sleep || st_r.sample_on);
  assign o_dlv_mon_en = alert_act && st_r.alert_cfg[ALR_DLV_EN];
  assign o_alv_mon_en = alert_act && st_r.alert_cfg[ALR_ALV_EN];
  assign o_ahv_mon_en = alert_act && st_r.alert_cfg[ALR_AHV_EN];
  assign o_dlv_trip_code = st_r.alert_cfg[ALR_DLV_LSB +: TRIP_W];
  assign o_alv_trip_code = st_r.alert_cfg[ALR_ALV_LSB +: TRIP_W];

  // Trip qualification
  assign pre_trip = (st_r.f[SRC_PRE_DIG] && o_precise_dig_en) ||
    (st_r.f[SRC_PRE_ANA] && o_precise_ana_en);
  assign dlv_hit = st_r.f[SRC_DLV] && o_dlv_mon_en;
  assign alv_hit = st_r.f[SRC_ALV] && o_alv_mon_en;
  assign ahv_hit = st_r.f[SRC_AHV] && o_ahv_mon_en;
  assign alert_rst = (dlv_hit && st_r.alert_cfg[ALR_DLV_RST]) ||
    (alv_hit && st_r.alert_cfg[ALR_ALV_RST]);
  assign irq_hits = {ahv_hit,
    alv_hit && !st_r.alert_cfg[ALR_ALV_RST],
    dlv_hit && !st_r.alert_cfg[ALR_DLV_RST]};
  // Pin is watched in every power mode, not gated by sleep state
  assign ext_low = !st_r.f[SRC_EXT_N];

  assign wr_ctrl = st_r.dp_wr && st_r.dp_addr == ADDR_CTRL;
  // Block bit in the same word also counts, so one write can't slip past
  assign sw_fire = wr_ctrl && i_hwdata[CTRL_SW_RST] &&
    !st_r.sw_block && !i_hwdata[CTRL_SW_BLOCK];
  assign wdt_fire = st_r.wdt_en && st_r.phase == PH_RUN &&
    st_r.wdt_cnt >= st_r.wdt_timeout;
  assign rst_evt = pre_trip || ext_low || sw_fire || wdt_fire ||
    alert_rst;

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = st_r.rdata;
  assign o_sys_rst_n = st_r.sys_rst_n;
  assign o_wake_req = st_r.wake;
  assign o_alert_irq = st_r.irq;

  always_comb begin
    st_nxt = st_r;
    // Three-stage input filter; first stage feeds only the second
    st_nxt.s1 = src;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < NSRC; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.f[i] = st_r.s3[i];
      end
    end

    // Bus address phase; zero wait states
    st_nxt.dp_wr = 1'b0;
    if (i_hsel && i_htrans[1] && i_hready) begin
      st_nxt.dp_wr = i_hwrite;
      st_nxt.dp_addr = i_haddr[7:0];
      if (!i_hwrite) begin
        case (i_haddr[7:0])
          ADDR_CTRL: st_nxt.rdata = 32'({st_r.ana_reg_en, 1'b0,
            st_r.wdt_en, st_r.sw_block, 1'b0});
          ADDR_ALERT: st_nxt.rdata = 32'(st_r.alert_cfg);
          ADDR_STATUS: st_nxt.rdata = 32'(st_r.status);
          ADDR_WDT: st_nxt.rdata = 32'(st_r.wdt_timeout);
          ADDR_SAMPLE: st_nxt.rdata = 32'(st_r.sample_period);
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Bus data phase writes
    if (st_r.dp_wr) begin
      case (st_r.dp_addr)
        ADDR_CTRL: begin
          st_nxt.sw_block = i_hwdata[CTRL_SW_BLOCK];
          st_nxt.ana_reg_en = i_hwdata[CTRL_ANA_REG];
          // Enable can be set but never cleared by software
          st_nxt.wdt_en = st_r.wdt_en | i_hwdata[CTRL_WDT_EN];
        end
        ADDR_ALERT: st_nxt.alert_cfg = i_hwdata[ALERT_W-1:0];
        ADDR_WDT: st_nxt.wdt_timeout = i_hwdata[WDT_W-1:0];
        ADDR_SAMPLE: st_nxt.sample_period = i_hwdata[15:0];
        default: ; // Read-only and unmapped words ignore writes
      endcase
    end

    // Watchdog counts only while running and enabled
    if (st_r.phase != PH_RUN ||
        (wr_ctrl && i_hwdata[CTRL_WDT_KICK])) begin
      st_nxt.wdt_cnt = '0;
    end else if (st_r.wdt_en) begin
      st_nxt.wdt_cnt = st_r.wdt_cnt + WDT_ONE;
    end

    // Periodic sampling window in sleep
    if (i_sleep && !i_hibernate) begin
      if (st_r.sample_on) begin
        st_nxt.on_cnt = st_r.on_cnt + 4'h1;
        if (st_r.on_cnt == SAMPLE_ON_CYC - 4'h1) begin
          st_nxt.sample_on = 1'b0;
          st_nxt.sample_cnt = 16'h0000;
        end
      end else begin
        st_nxt.sample_cnt = st_r.sample_cnt + 16'h0001;
        if (st_r.sample_cnt >= st_r.sample_period) begin
          st_nxt.sample_on = 1'b1;
          st_nxt.on_cnt = 4'h0;
        end
      end
    end else begin
      st_nxt.sample_on = 1'b0;
      st_nxt.sample_cnt = 16'h0000;
      st_nxt.on_cnt = 4'h0;
    end

    // Alert interrupt: wake first, deliver once awake and running
    st_nxt.irq = 1'b0;
    st_nxt.wake = 1'b0;
    if (st_r.pend != 3'h0) begin
      if (awake && st_r.phase == PH_RUN) begin
        st_nxt.irq = 1'b1;
        st_nxt.pend = 3'h0;
      end else if (i_sleep) begin
        st_nxt.wake = 1'b1;
      end
    end
    // New hits win over the clear in the same cycle
    st_nxt.pend = st_nxt.pend | irq_hits;

    // Status is sticky; nothing but power-on clears it
    st_nxt.status[STS_PRECISE] = st_r.status[STS_PRECISE] | pre_trip;
    st_nxt.status[STS_WDT] = st_r.status[STS_WDT] | wdt_fire;
    st_nxt.status[STS_SW] = st_r.status[STS_SW] | sw_fire;
    st_nxt.status[STS_EXT] = st_r.status[STS_EXT] |
      (ext_low && st_r.phase != PH_HOLD);
    st_nxt.status[STS_DLV] = st_r.status[STS_DLV] | dlv_hit;
    st_nxt.status[STS_ALV] = st_r.status[STS_ALV] | alv_hit;
    st_nxt.status[STS_AHV] = st_r.status[STS_AHV] | ahv_hit;

    // Reset sequencing
    case (st_r.phase)
      PH_HOLD: begin
        if (st_r.hold_cnt != 8'h00) begin
          st_nxt.hold_cnt = st_r.hold_cnt - 8'h01;
        end else if (!i_supply_ramping) begin
          st_nxt.phase = PH_BOOT;
        end
      end
      PH_BOOT: begin
        if (i_boot_done) begin
          st_nxt.phase = PH_RUN;
          st_nxt.boot_done = 1'b1;
          st_nxt.first_done = 1'b1;
        end
      end
      PH_RUN: st_nxt.phase = PH_RUN;
      default: st_nxt.phase = PH_HOLD;
    endcase

    // Every source gets the same power-on style response
    if (rst_evt) begin
      st_nxt.phase = PH_HOLD;
      st_nxt.hold_cnt = POR_PULSE_CYC;
      st_nxt.boot_done = 1'b0;
      st_nxt.sw_block = 1'b0;
      st_nxt.ana_reg_en = 1'b1;
      st_nxt.alert_cfg = ALERT_RST;
      st_nxt.wdt_timeout = WDT_TIMEOUT_RST;
      st_nxt.sample_period = SAMPLE_PERIOD_RST;
      st_nxt.wdt_cnt = '0;
      st_nxt.pend = 3'h0;
      st_nxt.irq = 1'b0;
    end

    // Registered so every reset domain releases on one edge
    st_nxt.sys_rst_n = st_nxt.phase != PH_HOLD;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.phase <= PH_HOLD;
      st_r.hold_cnt <= POR_PULSE_CYC;
      st_r.s1 <= SRC_IDLE;
      st_r.s2 <= SRC_IDLE;
      st_r.s3 <= SRC_IDLE;
      st_r.f <= SRC_IDLE;
      st_r.ana_reg_en <= 1'b1;
      st_r.alert_cfg <= ALERT_RST;
      st_r.wdt_timeout <= WDT_TIMEOUT_RST;
      st_r.sample_period <= SAMPLE_PERIOD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  reset_pulse_min_a: assert property (
    $fell(o_sys_rst_n) |-> !o_sys_rst_n [*4])
    else $error("system reset pulse shorter than minimum");
  precise_trip_a: assert property (
    pre_trip |=> !o_sys_rst_n ##1 !o_sys_rst_n)
    else $error("precise trip did not reset");
  ext_pin_hold_a: assert property (
    ext_low |=> !o_sys_rst_n && st_r.phase == PH_HOLD)
    else $error("external pin low but reset released");
  sw_reset_go_a: assert property (
    sw_fire |=> !o_sys_rst_n && st_r.status[STS_SW])
    else $error("software reset not taken");
  sw_reset_block_a: assert property (
    st_r.sw_block && !pre_trip && !ext_low && !wdt_fire && !alert_rst
      && st_r.phase == PH_RUN |=> o_sys_rst_n)
    else $error("blocked software reset took effect");
  wdt_fire_rst_a: assert property (
    wdt_fire |=> !o_sys_rst_n && st_r.status[STS_WDT])
    else $error("watchdog timeout without reset");
  wdt_idle_off_a: assert property (
    !st_r.wdt_en |-> st_r.wdt_cnt == '0)
    else $error("watchdog counting while disabled");
  wdt_en_sticky_a: assert property (
    st_r.wdt_en |=> st_r.wdt_en)
    else $error("watchdog enable cleared");
  status_sticky_a: assert property (
    1'b1 |=> (($past(st_r.status) & ~st_r.status) == '0))
    else $error("status bit cleared without power-on");
  precise_sleep_a: assert property (
    (i_hibernate || (i_sleep && !st_r.sample_on)) |-> !o_precise_dig_en)
    else $error("precise monitor on outside sample window");
  alert_gate_a: assert property (
    !st_r.first_done |-> !(o_dlv_mon_en || o_alv_mon_en || o_ahv_mon_en))
    else $error("alert monitor enabled before first boot");
  wake_first_a: assert property (
    (st_r.pend != 3'h0 && i_sleep) |=> o_wake_req && !o_alert_irq)
    else $error("sleep alert did not wake first");

  cover_wdt_c: cover property (wdt_fire ##1 !o_sys_rst_n);
  cover_sw_c: cover property (sw_fire ##[1:20] o_sys_rst_n);
  cover_irq_c: cover property (o_wake_req ##[1:50] o_alert_irq);
  cover_sample_c: cover property ($rose(st_r.sample_on));

endmodule // reset_source_controller

`default_nettype wire

// ---- common/rst_ctrl_pkg.sv ----
// Constants for the reset source controller: register map, field
// positions, reset values and timing counts.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register port.
`default_nettype none

package rst_ctrl_pkg;

  // Clock and reset pulse timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_PULSE_NS = 150;
  // Least time, rounded up to whole cycles
  localparam logic [7:0] POR_PULSE_CYC =
    8'((POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Far side must leave the pin released this long before reasserting
  localparam int EXT_REARM_US = 10;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ALERT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WDT = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLE = 8'h10;

  // Control register fields
  localparam int CTRL_SW_RST = 0;
  localparam int CTRL_SW_BLOCK = 1;
  localparam int CTRL_WDT_EN = 2;
  localparam int CTRL_WDT_KICK = 3;
  localparam int CTRL_ANA_REG = 4;

  // Alert configuration fields
  localparam int TRIP_W = 4;
  localparam int ALERT_W = 13;
  localparam int ALR_DLV_LSB = 0;
  localparam int ALR_ALV_LSB = 4;
  localparam int ALR_DLV_RST = 8;
  localparam int ALR_ALV_RST = 9;
  localparam int ALR_DLV_EN = 10;
  localparam int ALR_ALV_EN = 11;
  localparam int ALR_AHV_EN = 12;
  localparam logic [ALERT_W-1:0] ALERT_RST = 13'h0000;

  // Trip code n selects base + n * step; 16 codes reach 5450 mV
  localparam int TRIP_BASE_MV = 1700;
  localparam int TRIP_STEP_MV = 250;
  localparam int AHV_TRIP_MV = 5750;

  // Status register bits
  localparam int STATUS_W = 7;
  localparam int STS_PRECISE = 0;
  localparam int STS_WDT = 1;
  localparam int STS_SW = 2;
  localparam int STS_EXT = 3;
  localparam int STS_DLV = 4;
  localparam int STS_ALV = 5;
  localparam int STS_AHV = 6;

  // Indices into the synchronised supervision inputs
  localparam int NSRC = 6;
  localparam int SRC_PRE_DIG = 0;
  localparam int SRC_PRE_ANA = 1;
  localparam int SRC_DLV = 2;
  localparam int SRC_ALV = 3;
  localparam int SRC_AHV = 4;
  localparam int SRC_EXT_N = 5;
  localparam logic [NSRC-1:0] SRC_IDLE = 6'h20;

  // Sample period reset value and sample window length
  localparam logic [15:0] SAMPLE_PERIOD_RST = 16'h0400;
  localparam logic [3:0] SAMPLE_ON_CYC = 4'h8;

  typedef enum logic [1:0] {
    PH_HOLD,
    PH_BOOT,
    PH_RUN
  } phase_t;

endpackage

`default_nettype wire

// ---- testbench/ext_reset_drv.sv ----
// Far-side model: driver of the external reset pin, with pull-up.
// Assumes requests arrive just after rising edges of i_sys_clk.
`default_nettype none
module ext_reset_drv
  import rst_ctrl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [7:0] i_len,
  output logic o_pin_n,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REARM = EXT_REARM_US * 1000 / CLK_PERIOD_NS;
  int low_cnt = 0;
  int rearm = 0;
  // Released pin sits at the pull-up level
  assign o_pin_n = (low_cnt == 0);
  assign o_ready = (low_cnt == 0) && (rearm == 0);
  always @(posedge i_sys_clk) begin
    if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
      if (low_cnt == 1) rearm <= REARM;
    end else if (rearm > 0) begin
      // Requests in the rearm gap are dropped
      rearm <= rearm - 1;
    end else if (i_go) begin
      low_cnt <= int'(i_len);
    end
  end
endmodule // ext_reset_drv
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the reset source controller.
// Assumes a 25 MHz clock and a zero-wait AHB-Lite slave.
`default_nettype none
module testbench;
  import rst_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] WDT_T = 24'h000040;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic ramp = 0, boot = 0, sleep = 0, pdig = 0, pana = 0;
  logic dlv = 0, alv = 0, ahv = 0, go = 0, hib = 0;
  logic [7:0] len = 0, seed = 8'h30;
  logic [31:0] hrdata;
  logic hready, hresp, srst_n, por_en, pd_en, pa_en, samp_en;
  logic dlv_en, alv_en, ahv_en, wake, irq, pin_n, drv_rdy;
  logic [3:0] dcode, acode;
  int num_errors = 0, tests_run = 0, lo, bad;
  int mdl[5];

  reset_source_controller #(.WDT_TIMEOUT_RST(WDT_T))
    reset_source_controller_i (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_supply_ramping(ramp),
    .i_boot_done(boot), .i_sleep(sleep), .i_hibernate(hib),
    .i_precise_dig_trip(pdig), .i_precise_ana_trip(pana),
    .i_dlv_trip(dlv), .i_alv_trip(alv), .i_ahv_trip(ahv),
    .i_ext_reset_n(pin_n), .o_sys_rst_n(srst_n), .o_por_mon_en(por_en),
    .o_precise_dig_en(pd_en), .o_precise_ana_en(pa_en),
    .o_reg_sample_en(samp_en), .o_dlv_mon_en(dlv_en),
    .o_alv_mon_en(alv_en), .o_ahv_mon_en(ahv_en),
    .o_dlv_trip_code(dcode), .o_alv_trip_code(acode),
    .o_wake_req(wake), .o_alert_irq(irq));
  ext_reset_drv ext_reset_drv_i (.i_sys_clk(clk), .i_go(go),
    .i_len(len), .o_pin_n(pin_n), .o_ready(drv_rdy));

  initial forever #20 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t reg %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t port %b want %b", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    // One more edge so callers see the written value settled
    @(posedge clk);
    case (a)
      ADDR_CTRL: mdl[0] = int'((d & 32'h16) | (mdl[0] & 32'h4));
      ADDR_ALERT: mdl[1] = int'(d & 32'h1FFF);
      ADDR_WDT: mdl[3] = int'(d & 32'hFFFFFF);
      ADDR_SAMPLE: mdl[4] = int'(d & 32'hFFFF);
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_bit(hresp, 1'b0);
    chk_reg(r, (a < 8'h14 && a[1:0] == 2'b00) ? mdl[a >> 2] : 0);
  endtask

  task automatic booted();
    @(posedge clk);
    boot <= 1'b1;
    @(posedge clk);
    boot <= 1'b0;
    @(posedge clk);
  endtask

  task automatic por(input int rcyc);
    rst_n <= 1'b0;
    ramp <= rcyc > 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    lo = 0;
    while (srst_n !== 1'b1 && lo < 100) begin
      @(posedge clk);
      lo++;
      if (lo >= rcyc) ramp <= 1'b0;
    end
    chk_bit(srst_n, 1'b1);
    chk_bit(por_en, 1'b1);
    mdl = '{32'h10, 0, 0, int'(WDT_T), int'(SAMPLE_PERIOD_RST)};
    chk_bit(dlv_en | alv_en | ahv_en, 1'b0);
    booted();
  endtask

  // Waits for a system reset, then counts its low cycles
  task automatic catch_rst(input int b, input int wmax);
    lo = 0;
    for (int k = 0; k < wmax && srst_n !== 1'b0; k++) @(posedge clk);
    while (srst_n === 1'b0 && lo < 400) begin
      @(posedge clk);
      lo++;
    end
    mdl[0] = (mdl[0] & 4) | 32'h10;
    mdl[1] = 0;
    mdl[3] = int'(WDT_T);
    mdl[4] = int'(SAMPLE_PERIOD_RST);
    if (b >= 0) mdl[2] = mdl[2] | (1 << b);
  endtask

  task automatic trip(input logic [4:0] v);
    {pana, pdig, ahv, alv, dlv} <= v;
    repeat (4) @(posedge clk);
    {pana, pdig, ahv, alv, dlv} <= 5'h00;
  endtask

  initial begin
    #(40 * 30000);
    num_errors++;
    $display("unexpected %0t run took too long", $time);
    test_done();
  end

  initial begin
    por(20);
    chk_bit(lo >= 20, 1'b1);
    for (int a = 0; a < 24; a += 4) rd(8'(a));
    wr(ADDR_STATUS, 32'hFF);
    rd(ADDR_STATUS);
    chk_bit(por_en, 1'b0);
    chk_bit(pd_en, 1'b1);
    wr(ADDR_CTRL, 32'h0);
    chk_bit(pa_en, 1'b0);
    chk_bit(pd_en, 1'b1);
    wr(ADDR_CTRL, 32'h10);
    chk_bit(pa_en, 1'b1);
    $display("test reset values done");
    wr(ADDR_ALERT, 32'h123);
    wr(ADDR_CTRL, 32'h13);
    repeat (10) @(posedge clk);
    chk_bit(srst_n, 1'b1);
    rd(ADDR_CTRL);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_CTRL, 32'h11);
    catch_rst(STS_SW, 12);
    chk_bit(lo >= 5, 1'b1);
    rd(ADDR_STATUS);
    rd(ADDR_ALERT);
    rd(ADDR_CTRL);
    booted();
    $display("test software reset done");
    for (int i = 0; i < 2; i++) begin
      trip(i ? 5'h10 : 5'h08);
      catch_rst(STS_PRECISE, 12);
      chk_bit(lo >= 5, 1'b1);
      rd(ADDR_STATUS);
      booted();
    end
    $display("test precise monitor done");
    por(0);
    // First pulse in sleep, second in hibernate
    for (int m = 0; m < 2; m++) begin
      while (drv_rdy !== 1'b1) @(posedge clk);
      sleep <= (m == 0);
      hib <= (m == 1);
      len <= 8'd30;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      chk_bit(pd_en, 1'b0);
      catch_rst(STS_EXT, 12);
      sleep <= 1'b0;
      hib <= 1'b0;
      chk_bit(lo >= 30, 1'b1);
      rd(ADDR_STATUS);
      booted();
    end
    $display("test pin reset done");
    seed = lfsr(seed);
    wr(ADDR_ALERT, 32'h1C00 | seed);
    chk_reg(32'({acode, dcode}), 32'(seed));
    chk_bit(dlv_en & alv_en & ahv_en, 1'b1);
    for (int i = 0; i < 3; i++) begin
      trip(5'(1 << i));
      for (int k = 0; k < 12 && irq !== 1'b1; k++) @(posedge clk);
      chk_bit(irq, 1'b1);
      mdl[2] = mdl[2] | (1 << (STS_DLV + i));
      repeat (8) @(posedge clk);
    end
    rd(ADDR_STATUS);
    $display("test alert interrupts done");
    wr(ADDR_ALERT, 32'h500 | seed[3:0]);
    trip(5'h01);
    catch_rst(-1, 12);
    chk_bit(lo >= 5, 1'b1);
    rd(ADDR_ALERT);
    booted();
    wr(ADDR_SAMPLE, 32'h20);
    wr(ADDR_ALERT, 32'h400);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    dlv <= 1'b1;
    bad = 0;
    for (int k = 0; k < 120 && wake !== 1'b1; k++) begin
      @(posedge clk);
      if (pd_en === 1'b1 && samp_en !== 1'b1) bad++;
      if (irq !== 1'b0) bad++;
    end
    chk_bit(wake, 1'b1);
    chk_reg(32'(bad), 32'h0);
    dlv <= 1'b0;
    sleep <= 1'b0;
    for (int k = 0; k < 12 && irq !== 1'b1; k++) @(posedge clk);
    chk_bit(irq, 1'b1);
    $display("test sleep sampling done");
    por(0);
    wr(ADDR_CTRL, 32'h14);
    wr(ADDR_CTRL, 32'h10);
    rd(ADDR_CTRL);
    repeat (4) begin
      repeat (20) @(posedge clk);
      wr(ADDR_CTRL, 32'h1C);
    end
    chk_bit(srst_n, 1'b1);
    rd(ADDR_STATUS);
    catch_rst(STS_WDT, 100);
    chk_bit(lo >= 5, 1'b1);
    rd(ADDR_STATUS);
    rd(ADDR_CTRL);
    por(0);
    rd(ADDR_CTRL);
    $display("test watchdog done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
